/* File: rtl/tcp_timer_ctrl.sv */
// How it works
// [RL1] action 00 holds output, 01 clears it
// [RL2] action 10 sets output on match
// [RL3] action 11 toggles output on match
// [RL4] action fields at bits 11:4, reset 00
// [RL5] mode 0 counts every clock edge
// [RL6] counter mode compares two capture samples
// [RL7] modes 1/2/3 count rise/fall/both edges
// [RL8] input select 0 picks capture input 0
// [RL9] software zeroes capture control in counter mode
// [RL10] capture input at most half clock rate
// [RL11] reserved bits written zero, read undefined
// [RL12] pwm enable bit routes output per channel
// [RL13] three pwm outputs, one cycle-length match
// [RL14] pwm output set at its match value
// [RL15] cycle match resets timer, clears pwm
// [RL16] channel 3 preferred for cycle length
// [RL17] zero match value goes high, stays high
// [RL18] only cycle register resets on match
`timescale 1ns/10ps
module tcp_timer_ctrl
  import tcp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        capture_input_0,
  output logic      [3:0]  match_output_pin
);

  // ==========================================================
  // helpers
  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    logic res;
    res = cur;
    case (act)
      TCP_ACT_NONE:   res = cur;   // RL1
      TCP_ACT_CLEAR:  res = 1'b0;  // RL1
      TCP_ACT_SET:    res = 1'b1;  // RL2
      TCP_ACT_TOGGLE: res = ~cur;  // RL3
      default:        res = cur;
    endcase
    return res;
  endfunction

  function automatic logic wr_hit(input logic [31:0] addr, input logic [31:0] target);
    return addr == target;
  endfunction

  // ==========================================================
  // state
  logic [1:0]  timer_ctrl_r;
  logic [31:0] timer_count_value_r;
  logic [31:0] timer_count_value_nxt;
  logic [3:0]  reset_on_match_r;
  logic [31:0] match_val_r [TCP_NUM_CH];
  logic [3:0]  ext_match_r;
  logic [3:0]  ext_match_nxt;
  logic [7:0]  match_action_r;
  logic [1:0]  count_mode_r;
  logic [1:0]  count_input_select_r;
  logic [3:0]  pwm_enable_r;
  logic [3:0]  pwm_out_r;
  logic [3:0]  pwm_out_nxt;
  logic [3:0]  match_output_pin_r;
  logic [31:0] reg_rdata_r;
  logic [31:0] rd_mux;

  logic        run;
  logic        count_tick;
  logic [3:0]  equal;
  logic [3:0]  match_hit;
  logic        cycle_reset;

  tcp_edge_if edge_bus ();

  assign edge_bus.count_mode         = count_mode_r;
  assign edge_bus.count_input_select = count_input_select_r;

  tcp_edge_det u_edge_det (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .capture_input_0 (capture_input_0),
    .edge_bus        (edge_bus.det)
  );

  // ==========================================================
  // count qualification
  // hold bit wins over enable and pins the count at zero
  assign run = timer_ctrl_r[TCP_TCR_ENABLE_BIT] & ~timer_ctrl_r[TCP_TCR_RESET_BIT];

  always_comb begin
    if (count_mode_r == TCP_MODE_TIMER) begin
      count_tick = run; // RL5
    end else begin
      count_tick = run & edge_bus.count_event; // RL7
    end
  end

  // a match acts on the tick that leaves the matched value, so the
  // matched count lasts a full tick before reset or external match change
  always_comb begin
    for (int i = 0; i < TCP_NUM_CH; i++) begin
      equal[i]     = timer_count_value_r == match_val_r[i];
      match_hit[i] = count_tick & equal[i];
    end
  end

  // the cycle-length channel is whichever has reset-on-match set
  assign cycle_reset = |(match_hit & reset_on_match_r); // RL15 RL18

  always_comb begin
    if (timer_ctrl_r[TCP_TCR_RESET_BIT]) begin
      timer_count_value_nxt = TCP_WORD_RST;
    end else if (cycle_reset) begin
      timer_count_value_nxt = TCP_WORD_RST; // RL15
    end else if (count_tick) begin
      timer_count_value_nxt = timer_count_value_r + 32'h0000_0001;
    end else begin
      timer_count_value_nxt = timer_count_value_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_count_value_r <= TCP_WORD_RST;
    end else if (reg_wr && wr_hit(reg_addr, TCP_ADDR_TIMER_COUNT)) begin
      timer_count_value_r <= reg_wdata;
    end else begin
      timer_count_value_r <= timer_count_value_nxt;
    end
  end

  // ==========================================================
  // external match bits
  // hardware match action wins over a software write in the same cycle
  always_comb begin
    ext_match_nxt = ext_match_r;
    if (reg_wr && wr_hit(reg_addr, TCP_ADDR_EXT_MATCH)) begin
      ext_match_nxt = reg_wdata[TCP_EXT_BITS_LSB +: TCP_NUM_CH];
    end
    for (int i = 0; i < TCP_NUM_CH; i++) begin
      if (match_hit[i]) begin
        ext_match_nxt[i] = apply_action(
          match_action_r[TCP_ACTION_LSB - TCP_ACTION_LSB + i*TCP_ACTION_W +: TCP_ACTION_W],
          ext_match_r[i]); // RL1 RL2 RL3 RL4
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_match_r    <= TCP_NIBBLE_RST;
      match_action_r <= TCP_ACTION_RST; // RL4
    end else begin
      ext_match_r <= ext_match_nxt;
      if (reg_wr && wr_hit(reg_addr, TCP_ADDR_EXT_MATCH)) begin
        match_action_r <= reg_wdata[TCP_ACTION_LSB +: TCP_NUM_CH*TCP_ACTION_W]; // RL4
      end
    end
  end

  // ==========================================================
  // single-edge pwm
  // a match value beyond the cycle length never sets its output
  always_comb begin
    for (int i = 0; i < TCP_NUM_CH; i++) begin
      if (cycle_reset) begin
        // a zero match value is high from the first return to zero on
        pwm_out_nxt[i] = match_val_r[i] == TCP_WORD_RST; // RL15 RL17
      end else if (run && equal[i] && !reset_on_match_r[i]
                   && match_val_r[i] != TCP_WORD_RST) begin
        pwm_out_nxt[i] = 1'b1; // RL14 RL13
      end else begin
        pwm_out_nxt[i] = pwm_out_r[i];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwm_out_r <= TCP_NIBBLE_RST;
    end else begin
      pwm_out_r <= pwm_out_nxt;
    end
  end

  // ==========================================================
  // output routing, registered so the pins never glitch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      match_output_pin_r <= TCP_NIBBLE_RST;
    end else begin
      for (int i = 0; i < TCP_NUM_CH; i++) begin
        match_output_pin_r[i] <= pwm_enable_r[i] ? pwm_out_nxt[i] : ext_match_nxt[i]; // RL12
      end
    end
  end

  assign match_output_pin = match_output_pin_r;

  // ==========================================================
  // configuration registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_ctrl_r <= TCP_TCR_RST;
    end else if (reg_wr && wr_hit(reg_addr, TCP_ADDR_TIMER_CTRL)) begin
      timer_ctrl_r <= reg_wdata[TCP_TCR_ENABLE_BIT +: TCP_TCR_W];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_mode_r         <= TCP_MODE_TIMER; // RL5
      count_input_select_r <= TCP_SEL_CAP0;   // RL8
    end else if (reg_wr && wr_hit(reg_addr, TCP_ADDR_COUNT_SRC)) begin
      // upper bits are dropped; software is expected to write zeros
      count_mode_r         <= reg_wdata[TCP_MODE_LSB +: TCP_MODE_W]; // RL11
      count_input_select_r <= reg_wdata[TCP_SEL_LSB +: TCP_SEL_W];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwm_enable_r <= TCP_NIBBLE_RST; // RL12
    end else if (reg_wr && wr_hit(reg_addr, TCP_ADDR_PWM_CTRL)) begin
      pwm_enable_r <= reg_wdata[TCP_PWM_LSB +: TCP_NUM_CH]; // RL11
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_on_match_r <= TCP_NIBBLE_RST;
    end else if (reg_wr && wr_hit(reg_addr, TCP_ADDR_MATCH_CTRL)) begin
      reset_on_match_r <= reg_wdata[TCP_MATCH_RST_LSB +: TCP_NUM_CH];
    end
  end

  // a new match value applies at once, even while the timer runs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < TCP_NUM_CH; i++) begin
        match_val_r[i] <= TCP_WORD_RST;
      end
    end else if (reg_wr) begin
      if (wr_hit(reg_addr, TCP_ADDR_MATCH_VAL0)) begin
        match_val_r[0] <= reg_wdata;
      end else if (wr_hit(reg_addr, TCP_ADDR_MATCH_VAL1)) begin
        match_val_r[1] <= reg_wdata;
      end else if (wr_hit(reg_addr, TCP_ADDR_MATCH_VAL2)) begin
        match_val_r[2] <= reg_wdata;
      end else if (wr_hit(reg_addr, TCP_ADDR_MATCH_VAL3)) begin
        match_val_r[3] <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // read path: reserved bits and unmapped addresses read as zero
  always_comb begin
    rd_mux = TCP_WORD_RST;
    if (reg_addr == TCP_ADDR_TIMER_CTRL) begin
      rd_mux[TCP_TCR_ENABLE_BIT +: TCP_TCR_W] = timer_ctrl_r;
    end else if (reg_addr == TCP_ADDR_TIMER_COUNT) begin
      rd_mux = timer_count_value_r;
    end else if (reg_addr == TCP_ADDR_MATCH_CTRL) begin
      rd_mux[TCP_MATCH_RST_LSB +: TCP_NUM_CH] = reset_on_match_r;
    end else if (reg_addr == TCP_ADDR_MATCH_VAL0) begin
      rd_mux = match_val_r[0];
    end else if (reg_addr == TCP_ADDR_MATCH_VAL1) begin
      rd_mux = match_val_r[1];
    end else if (reg_addr == TCP_ADDR_MATCH_VAL2) begin
      rd_mux = match_val_r[2];
    end else if (reg_addr == TCP_ADDR_MATCH_VAL3) begin
      rd_mux = match_val_r[3];
    end else if (reg_addr == TCP_ADDR_EXT_MATCH) begin
      rd_mux[TCP_EXT_BITS_LSB +: TCP_NUM_CH] = ext_match_r;
      rd_mux[TCP_ACTION_LSB +: TCP_NUM_CH*TCP_ACTION_W] = match_action_r;
    end else if (reg_addr == TCP_ADDR_COUNT_SRC) begin
      rd_mux[TCP_MODE_LSB +: TCP_MODE_W] = count_mode_r;
      rd_mux[TCP_SEL_LSB +: TCP_SEL_W]   = count_input_select_r; // RL11
    end else if (reg_addr == TCP_ADDR_PWM_CTRL) begin
      rd_mux[TCP_PWM_LSB +: TCP_NUM_CH] = pwm_enable_r; // RL11
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= TCP_WORD_RST;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_mux;
    end else begin
      reg_rdata_r <= TCP_WORD_RST;
    end
  end

  assign reg_rdata = reg_rdata_r;

endmodule

/* File: rtl/tcp_pkg.sv */
package tcp_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [31:0] TCP_ADDR_TIMER_CTRL  = 32'h4001_4004;
  localparam logic [31:0] TCP_ADDR_TIMER_COUNT = 32'h4001_4008;
  localparam logic [31:0] TCP_ADDR_MATCH_CTRL  = 32'h4001_4014;
  localparam logic [31:0] TCP_ADDR_MATCH_VAL0  = 32'h4001_4018;
  localparam logic [31:0] TCP_ADDR_MATCH_VAL1  = 32'h4001_401C;
  localparam logic [31:0] TCP_ADDR_MATCH_VAL2  = 32'h4001_4020;
  localparam logic [31:0] TCP_ADDR_MATCH_VAL3  = 32'h4001_4024;
  localparam logic [31:0] TCP_ADDR_EXT_MATCH   = 32'h4001_403C;
  localparam logic [31:0] TCP_ADDR_COUNT_SRC   = 32'h4001_4070;
  localparam logic [31:0] TCP_ADDR_PWM_CTRL    = 32'h4001_4074;

  // ==========================================================
  // field layout
  localparam int TCP_NUM_CH          = 4;
  localparam int TCP_TCR_ENABLE_BIT  = 0;
  localparam int TCP_TCR_RESET_BIT   = 1;
  localparam int TCP_EXT_BITS_LSB    = 0;
  localparam int TCP_ACTION_LSB      = 4;
  localparam int TCP_ACTION_W        = 2;
  localparam int TCP_MODE_LSB        = 0;
  localparam int TCP_SEL_LSB         = 2;
  localparam int TCP_PWM_LSB         = 0;
  localparam int TCP_MATCH_RST_LSB   = 0;
  localparam int TCP_TCR_W           = 2;
  localparam int TCP_MODE_W          = 2;
  localparam int TCP_SEL_W           = 2;

  // ==========================================================
  // reset values
  localparam logic [1:0]  TCP_TCR_RST    = 2'h0;
  localparam logic [31:0] TCP_WORD_RST   = 32'h0000_0000;
  localparam logic [3:0]  TCP_NIBBLE_RST = 4'h0;
  localparam logic [7:0]  TCP_ACTION_RST = 8'h00;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    TCP_ACT_NONE   = 2'b00,
    TCP_ACT_CLEAR  = 2'b01,
    TCP_ACT_SET    = 2'b10,
    TCP_ACT_TOGGLE = 2'b11
  } tcp_action_e;

  typedef enum logic [1:0] {
    TCP_MODE_TIMER = 2'b00,
    TCP_MODE_RISE  = 2'b01,
    TCP_MODE_FALL  = 2'b10,
    TCP_MODE_BOTH  = 2'b11
  } tcp_mode_e;

  localparam logic [1:0] TCP_SEL_CAP0 = 2'h0;

endpackage

/* File: rtl/tcp_edge_if.sv */
`timescale 1ns/10ps
interface tcp_edge_if;
  import tcp_pkg::*;
  logic [1:0] count_mode;
  logic [1:0] count_input_select;
  logic       count_event;

  modport det (
    input  count_mode,
    input  count_input_select,
    output count_event
  );
  modport ctl (
    output count_mode,
    output count_input_select,
    input  count_event
  );
endinterface

/* File: rtl/tcp_edge_det.sv */
`timescale 1ns/10ps
module tcp_edge_det
  import tcp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic capture_input_0,
  tcp_edge_if.det   edge_bus
);

  // ==========================================================
  // synchroniser, then one more sample for the compare
  logic cap_meta_r;
  logic cap_sync_r;
  logic cap_prev_r;
  logic rise;
  logic fall;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cap_meta_r <= 1'b0;
      cap_sync_r <= 1'b0;
      cap_prev_r <= 1'b0;
    end else begin
      cap_meta_r <= capture_input_0;
      cap_sync_r <= cap_meta_r;
      cap_prev_r <= cap_sync_r; // RL6
    end
  end

  // two consecutive samples give rise, fall, or no change
  assign rise = cap_sync_r & ~cap_prev_r; // RL6
  assign fall = ~cap_sync_r & cap_prev_r; // RL6

  // reserved input selections never produce an event
  always_comb begin
    edge_bus.count_event = 1'b0;
    if (edge_bus.count_input_select == TCP_SEL_CAP0) begin // RL8
      case (edge_bus.count_mode)
        TCP_MODE_RISE:  edge_bus.count_event = rise; // RL7
        TCP_MODE_FALL:  edge_bus.count_event = fall; // RL7
        TCP_MODE_BOTH:  edge_bus.count_event = rise | fall; // RL7
        default:        edge_bus.count_event = 1'b0;
      endcase
    end
  end

endmodule

/* File: dv/tcp_pulse_src.sv */
`timescale 1ns/10ps
module tcp_pulse_src (
  input  wire logic ref_clk,
  output logic      capture_input_0
);
  initial capture_input_0 <= 1'b0;
  // ==========
  // pulse train
  // every level is held for hold clocks, so the rate stays well under half the clock
  task automatic send_pulses(input int n, input int hold);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge ref_clk);
      capture_input_0 <= ~capture_input_0;
      repeat (hold - 1) @(posedge ref_clk);
    end
  endtask
endmodule

/* File: dv/tcp_timer_ctrl_chk.sv */
`timescale 1ns/10ps
module tcp_timer_ctrl_chk
  import tcp_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        capture_input_0,
  input wire logic [3:0]  match_output_pin
);
  // ==========
  // shadow of software fields
  logic [3:0] src_r;
  logic [3:0] pwm_r;
  logic [7:0] act_r;
  logic [1:0] quiet_r;
  wire        wr_ext = reg_wr && reg_addr == TCP_ADDR_EXT_MATCH;
  wire        wr_pwm = reg_wr && reg_addr == TCP_ADDR_PWM_CTRL;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src_r <= 4'h0;
      pwm_r <= 4'h0;
      act_r <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == TCP_ADDR_COUNT_SRC) src_r <= reg_wdata[3:0];
      if (wr_pwm) pwm_r <= reg_wdata[3:0];
      if (wr_ext) act_r <= reg_wdata[11:4];
    end
  end
  // a software write may move a pin, so pins are judged two edges later
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) quiet_r <= 2'h0;
    else if (wr_ext || wr_pwm) quiet_r <= 2'h0;
    else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
  end
  // ==========
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rd_src; reg_rd && reg_addr == TCP_ADDR_COUNT_SRC; endsequence
  sequence s_rd_pwm; reg_rd && reg_addr == TCP_ADDR_PWM_CTRL; endsequence
  sequence s_rd_ext; reg_rd && reg_addr == TCP_ADDR_EXT_MATCH; endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  src_read_a: assert property (s_rd_src |=> reg_rdata == {28'h000_0000, src_r})
    else $error("count source readback wrong");
  pwm_read_a: assert property (s_rd_pwm |=> reg_rdata == {28'h000_0000, pwm_r})
    else $error("pwm enable readback wrong");
  act_read_a: assert property (s_rd_ext |=> reg_rdata[11:4] == act_r)
    else $error("match action readback wrong");
  pins_reset_a: assert property ($fell(rst) |-> match_output_pin == 4'h0)
    else $error("match pins not low after reset");
  for (genvar n = 0; n < 4; n++) begin : g_ch
    wire       ext_only = quiet_r[1] && !pwm_r[n];
    wire [1:0] act      = act_r[2*n+:2];
    none_hold_a: assert property (
      ext_only && act == 2'b00 |-> $stable(match_output_pin[n]))
      else $error("pin moved with action none");
    clear_no_rise_a: assert property (
      ext_only && act == 2'b01 |-> !$rose(match_output_pin[n]))
      else $error("pin rose with action clear");
    set_no_fall_a: assert property (
      ext_only && act == 2'b10 |-> !$fell(match_output_pin[n]))
      else $error("pin fell with action set");
  end
endmodule

bind tcp_timer_ctrl tcp_timer_ctrl_chk tcp_timer_ctrl_chk_inst (
  .ref_clk          (ref_clk),
  .rst              (rst),
  .reg_addr         (reg_addr),
  .reg_wdata        (reg_wdata),
  .reg_wr           (reg_wr),
  .reg_rd           (reg_rd),
  .reg_rdata        (reg_rdata),
  .capture_input_0  (capture_input_0),
  .match_output_pin (match_output_pin)
);

/* File: dv/tcp_timer_ctrl_tb.sv */
`timescale 1ns/10ps
module tcp_timer_ctrl_tb;
  import tcp_pkg::*;
  localparam logic [31:0] CNT = TCP_ADDR_TIMER_COUNT;
  localparam logic [31:0] CTL = TCP_ADDR_TIMER_CTRL;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [31:0] reg_addr  = 32'h0000_0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        cap;
  logic [3:0]  pins;
  logic [31:0] d;
  int          errors      = 0;
  int          comparisons = 0;
  int          hi [3];
  logic [3:0]  src_t [4] = '{4'h1, 4'h2, 4'h3, 4'h5};
  logic [3:0]  exp_t [4] = '{4'h3, 4'h3, 4'h6, 4'h0};
  always #10 ref_clk = ~ref_clk;
  tcp_timer_ctrl tcp_timer_ctrl_inst (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .capture_input_0  (cap),
    .match_output_pin (pins)
  );
  tcp_pulse_src tcp_pulse_src_inst (
    .ref_clk         (ref_clk),
    .capture_input_0 (cap)
  );
  // ==========
  // access tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d & m, e);
  endtask
  task automatic run(input int n);
    wr(CNT, 32'h0000_0000);
    wr(CTL, 32'h0000_0001);
    repeat (n) @(posedge ref_clk);
    wr(CTL, 32'h0000_0000);
  endtask
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    errors++;
    wrap_up();
  end
  // ==========
  // scenarios
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(TCP_ADDR_COUNT_SRC, ALL, 32'h0000_0000);
    rdc(TCP_ADDR_PWM_CTRL, ALL, 32'h0000_0000);
    rdc(TCP_ADDR_EXT_MATCH, 32'h0000_0FF0, 32'h0000_0000);
    rdc(32'h4001_40F0, ALL, 32'h0000_0000);
    // twelve enabled edges between the two control writes
    run(10);
    rdc(CNT, ALL, 32'h0000_000C);
    for (int i = 0; i < 4; i++) begin
      // capture control sits outside this block and stays at its reset zero
      wr(TCP_ADDR_COUNT_SRC, {28'h000_0000, src_t[i]});
      wr(CNT, 32'h0000_0000);
      wr(CTL, 32'h0000_0001);
      tcp_pulse_src_inst.send_pulses(3, 3);
      repeat (6) @(posedge ref_clk);
      wr(CTL, 32'h0000_0000);
      rdc(CNT, ALL, {28'h000_0000, exp_t[i]});
    end
    wr(TCP_ADDR_COUNT_SRC, 32'h0000_0000);
    // one channel per action: none, clear, set, toggle
    wr(TCP_ADDR_MATCH_VAL0, 32'h0000_0005);
    wr(TCP_ADDR_MATCH_VAL1, 32'h0000_0005);
    wr(TCP_ADDR_MATCH_VAL2, 32'h0000_0005);
    wr(TCP_ADDR_MATCH_VAL3, 32'h0000_0005);
    wr(TCP_ADDR_EXT_MATCH, 32'h0000_0E43);
    for (int k = 0; k < 2; k++) begin
      run(10);
      #1;
      chk({28'h000_0000, pins}, k ? 32'h0000_0005 : 32'h0000_000D);
      rdc(TCP_ADDR_EXT_MATCH, 32'h0000_0FFF, k ? 32'h0000_0E45 : 32'h0000_0E4D);
    end
    // pwm: cycle on channel 3, one early match, one zero, one beyond the cycle
    wr(TCP_ADDR_EXT_MATCH, 32'h0000_0000);
    wr(TCP_ADDR_MATCH_CTRL, 32'h0000_0008);
    wr(TCP_ADDR_MATCH_VAL0, 32'h0000_0003);
    wr(TCP_ADDR_MATCH_VAL1, 32'h0000_0000);
    wr(TCP_ADDR_MATCH_VAL2, 32'h0000_0014);
    wr(TCP_ADDR_MATCH_VAL3, 32'h0000_0009);
    wr(TCP_ADDR_PWM_CTRL, 32'h0000_0007);
    wr(CNT, 32'h0000_0000);
    wr(CTL, 32'h0000_0001);
    repeat (20) @(posedge ref_clk);
    hi = '{0, 0, 0};
    repeat (50) begin
      @(posedge ref_clk);
      #1;
      for (int c = 0; c < 3; c++) hi[c] += pins[c];
    end
    chk(32'(hi[0]), 32'h0000_001E);
    chk(32'(hi[1]), 32'h0000_0032);
    chk(32'(hi[2]), 32'h0000_0000);
    chk(32'(pins[3]), 32'h0000_0000);
    wr(CTL, 32'h0000_0000);
    rdc(CNT, 32'hFFFF_FFF0, 32'h0000_0000);
    // hold bit beside enable: count goes to zero and stays there
    wr(CTL, 32'h0000_0003);
    repeat (4) @(posedge ref_clk);
    rdc(CNT, ALL, 32'h0000_0000);
    wrap_up();
  end
endmodule
